// file: hdl/pmon_pkg.sv
/*
  Package for the phase mode, ADC readback and zero-cross register bank.
  Holds register offsets, reset values, field layouts, the lock key and
  the averaging sample timing. Assumes a 40 MHz system clock.
*/
`default_nettype none

package pmon_pkg;

  // ***************************************************************
  // Register offsets on the serial programming port
  // ***************************************************************
  localparam logic [7:0] LOCK_OFFSET     = 8'h00;
  localparam logic [7:0] MODE_OFFSET     = 8'h2d;
  localparam logic [7:0] IMON_RES_OFFSET = 8'h2e;
  localparam logic [7:0] VSEN_RES_OFFSET = 8'h2f;
  localparam logic [7:0] TSEN_RES_OFFSET = 8'h30;
  localparam logic [7:0] IMON_AVG_OFFSET = 8'h31;
  localparam logic [7:0] VSEN_AVG_OFFSET = 8'h32;
  localparam logic [7:0] TSEN_AVG_OFFSET = 8'h33;
  localparam logic [7:0] ZC_OFFSET       = 8'h34;

  // ***************************************************************
  // Lock key and reset values
  // ***************************************************************
  localparam logic [7:0] LOCK_KEY        = 8'ha6;
  localparam logic [7:0] LOCK_RESET      = 8'h00;
  localparam logic [2:0] MODE_RESET      = 3'h2;
  localparam logic [1:0] AVG_RESET       = 2'h0;
  localparam logic [5:0] ZC_RESET        = 6'h32;
  localparam logic [7:0] RES_RESET       = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_RESET = 8'h00;

  // ***************************************************************
  // Field layouts
  // ***************************************************************
  typedef struct packed {
    logic strap_lock_high;   // Bit 2: force internal power state high while strap three floats.
    logic pulse_skip_off;    // Bit 1: disable pulse skip at low level.
    logic shed_off;          // Bit 0: disable shedding at mid level.
  } mode_cfg_t;

  typedef struct packed {
    logic       offset_en;   // Bit 5: apply the threshold offset.
    logic       negative;    // Bit 4: 1 gives a negative threshold.
    logic [3:0] magnitude;   // Bits 3:0: steps of 0.31 mV.
  } zc_cfg_t;

  // Power state level codes as delivered by the level comparators.
  localparam logic [1:0] PS_LOW  = 2'h0;
  localparam logic [1:0] PS_MID  = 2'h1;
  localparam logic [1:0] PS_HIGH = 2'h2;

  // Averaging selector codes.
  localparam logic [1:0] AVG_SEL_8  = 2'h0;
  localparam logic [1:0] AVG_SEL_4  = 2'h1;
  localparam logic [1:0] AVG_SEL_2  = 2'h2;
  localparam logic [1:0] AVG_SEL_16 = 2'h3;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_FREQ_KHZ      = 40000;
  localparam int AVG_DEFAULT_COUNT = 8;
  localparam int IMON_WINDOW8_US   = 112;
  localparam int VSEN_WINDOW8_US   = 336;
  localparam int TSEN_WINDOW8_US   = 336;
  localparam int IMON_SAMPLE_CYC   = IMON_WINDOW8_US * CLK_FREQ_KHZ / 1000 / AVG_DEFAULT_COUNT;
  localparam int VSEN_SAMPLE_CYC   = VSEN_WINDOW8_US * CLK_FREQ_KHZ / 1000 / AVG_DEFAULT_COUNT;
  localparam int TSEN_SAMPLE_CYC   = TSEN_WINDOW8_US * CLK_FREQ_KHZ / 1000 / AVG_DEFAULT_COUNT;

  // Zero-cross threshold step in microvolts, for users of the offset code.
  localparam int ZC_STEP_UV = 310;

endpackage

`default_nettype wire

// file: hdl/sync2.sv
/*
  Two flip-flop synchroniser for a group of level inputs.
  Assumes each bit is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         mclk_i,
  input  wire logic         rst_b_i,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

`default_nettype wire

// file: hdl/adc_averager.sv
/*
  Averager for one ADC channel.
  Takes one code every SAMPLE_CYC clocks and holds the mean of the last
  window of 8, 4, 2 or 16 samples. Assumes the code input comes from the
  converter on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_averager
  import pmon_pkg::*;
#(
  parameter int SAMPLE_CYC = IMON_SAMPLE_CYC
) (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // Sample and window select.
  input  wire logic [7:0] code_i,
  input  wire logic [1:0] sel_i,
  // Averaged result.
  output var  logic [7:0] result_o
);

  localparam int TW = $clog2(SAMPLE_CYC);
  localparam logic [TW-1:0] TICK_LAST = TW'(SAMPLE_CYC - 1);

  logic [TW-1:0] tick_r;
  logic [11:0]   acc_r;
  logic [4:0]    n_r;
  logic [1:0]    sel_q_r;
  logic [11:0]   sum;

  function automatic logic [4:0] last_index(input logic [1:0] s);
    case (s)
      AVG_SEL_4:  last_index = 5'h03;
      AVG_SEL_2:  last_index = 5'h01;
      AVG_SEL_16: last_index = 5'h0f;
      default:    last_index = 5'h07;
    endcase
  endfunction

  function automatic logic [2:0] avg_shift(input logic [1:0] s);
    case (s)
      AVG_SEL_4:  avg_shift = 3'h2;
      AVG_SEL_2:  avg_shift = 3'h1;
      AVG_SEL_16: avg_shift = 3'h4;
      default:    avg_shift = 3'h3;
    endcase
  endfunction

  assign sum = acc_r + {4'h0, code_i};

  // A new window size restarts the window, so no mean mixes two sizes.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_r   <= '0;
      acc_r    <= 12'h000;
      n_r      <= 5'h00;
      sel_q_r  <= AVG_RESET;
      result_o <= RES_RESET;
    end else if (sel_i != sel_q_r) begin
      sel_q_r <= sel_i;
      tick_r  <= '0;
      acc_r   <= 12'h000;
      n_r     <= 5'h00;
    end else if (tick_r == TICK_LAST) begin
      tick_r <= '0;
      if (n_r == last_index(sel_q_r)) begin
        result_o <= 8'(sum >> avg_shift(sel_q_r));
        acc_r    <= 12'h000;
        n_r      <= 5'h00;
      end else begin
        acc_r <= sum;
        n_r   <= n_r + 5'h01;
      end
    end else begin
      tick_r <= tick_r + TW'(1);
    end
  end

endmodule

`default_nettype wire

// file: hdl/phase_mode_adc_monitor_regs.sv
/*
  Phase mode, ADC readback and zero-cross register bank of a multi-phase
  buck controller, reached over the two-wire serial programming port.
  Assumes asynchronous scl/sda, power-state and strap pins, and ADC codes
  and a slave address that are already on the system clock.
  // What this block does
  // - Floating strap three with mode bit 2 set forces internal power state high.
  // - At low power state, mode bit 1 clear enables pulse skip; resets to 1.
  // - At mid power state, mode bit 0 clear enables shedding, else all phases.
  // - Current monitor result reads as 8-bit code, 6.25 mV steps, resets zero.
  // - Voltage sense result reads at next offset, 6.25 mV steps, resets zero.
  // - Temperature sense result reads as 8-bit code, 12.5 mV steps, resets zero.
  // - Current monitor averages 8, 4, 2 or 16 samples by its 2-bit field.
  // - Voltage sense averages 8, 4, 2 or 16 samples by its 2-bit field.
  // - Temperature sense averages like voltage sense by its own 2-bit field.
  // - Zero-cross offset applies only while its enable bit is set.
  // - Zero-cross threshold is magnitude times 0.31 mV, sign from bit 4.
  // - Config fields take writes only while the lock register is not the key.
*/
`timescale 1ns/1ps
`default_nettype none

module phase_mode_adc_monitor_regs
  import pmon_pkg::*;
#(
  parameter int IMON_CYC = IMON_SAMPLE_CYC,
  parameter int VSEN_CYC = VSEN_SAMPLE_CYC,
  parameter int TSEN_CYC = TSEN_SAMPLE_CYC
) (
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // Serial programming port, open drain.
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe_o,
  input  wire logic [6:0] slave_addr_i,
  // Power state and strap pins.
  input  wire logic [1:0] power_state_input_i,
  input  wire logic       strap_pin_three_float_i,
  // Converter codes.
  input  wire logic [7:0] current_monitor_voltage_code_i,
  input  wire logic [7:0] voltage_sense_code_i,
  input  wire logic [7:0] temperature_sense_voltage_code_i,
  // Controls to the power stage.
  output var  logic [1:0] power_state_eff_o,
  output var  logic       pulse_skip_en_o,
  output var  logic       auto_phase_shedding_en_o,
  output var  logic       full_phase_o,
  output var  logic       zero_cross_detect_offset_en_o,
  output var  logic [4:0] zero_cross_detect_offset_o
);

  // ***************************************************************
  // Pin synchronisation
  // ***************************************************************
  logic       scl_s;
  logic       sda_s;
  logic [1:0] psi_s;
  logic       strap_s;

  sync2 #(.W(5)) u_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .async_i ({strap_pin_three_float_i, power_state_input_i, sda_i, scl_i}),
    .sync_o  ({strap_s, psi_s, sda_s, scl_s})
  );

  // ***************************************************************
  // Register storage
  // ***************************************************************
  logic [7:0] lock_r;
  mode_cfg_t  mode_r;
  logic [1:0] imon_avg_r, vsen_avg_r, tsen_avg_r;
  zc_cfg_t    zc_r;
  logic [7:0] imon_res, vsen_res, tsen_res;
  logic       wr_stb_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;

  // ***************************************************************
  // Averagers
  // ***************************************************************
  adc_averager #(.SAMPLE_CYC(IMON_CYC)) u_imon_avg (
    .mclk_i   (mclk_i),
    .rst_b_i  (rst_b_i),
    .code_i   (current_monitor_voltage_code_i),
    .sel_i    (imon_avg_r),
    .result_o (imon_res)
  );
  adc_averager #(.SAMPLE_CYC(VSEN_CYC)) u_vsen_avg (
    .mclk_i   (mclk_i),
    .rst_b_i  (rst_b_i),
    .code_i   (voltage_sense_code_i),
    .sel_i    (vsen_avg_r),
    .result_o (vsen_res)
  );
  adc_averager #(.SAMPLE_CYC(TSEN_CYC)) u_tsen_avg (
    .mclk_i   (mclk_i),
    .rst_b_i  (rst_b_i),
    .code_i   (temperature_sense_voltage_code_i),
    .sel_i    (tsen_avg_r),
    .result_o (tsen_res)
  );

  // Read decode; offsets this bank does not own read as zero.
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    case (a)
      LOCK_OFFSET:     reg_read = lock_r;
      MODE_OFFSET:     reg_read = {5'h00, mode_r};
      IMON_RES_OFFSET: reg_read = imon_res;
      VSEN_RES_OFFSET: reg_read = vsen_res;
      TSEN_RES_OFFSET: reg_read = tsen_res;
      IMON_AVG_OFFSET: reg_read = {6'h00, imon_avg_r};
      VSEN_AVG_OFFSET: reg_read = {6'h00, vsen_avg_r};
      TSEN_AVG_OFFSET: reg_read = {6'h00, tsen_avg_r};
      ZC_OFFSET:       reg_read = {2'h0, zc_r};
      default:         reg_read = 8'h00;
    endcase
  endfunction

  // ***************************************************************
  // Register writes
  // ***************************************************************
  // The lock register itself is always writable, otherwise software
  // could never leave the key value.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_r     <= LOCK_RESET;
      mode_r     <= MODE_RESET;
      imon_avg_r <= AVG_RESET;
      vsen_avg_r <= AVG_RESET;
      tsen_avg_r <= AVG_RESET;
      zc_r       <= ZC_RESET;
    end else if (wr_stb_r) begin
      if (wr_addr_r == LOCK_OFFSET) begin
        lock_r <= wr_data_r;
      end else if (lock_r != LOCK_KEY) begin
        case (wr_addr_r)
          MODE_OFFSET:     mode_r     <= wr_data_r[2:0];
          IMON_AVG_OFFSET: imon_avg_r <= wr_data_r[1:0];
          VSEN_AVG_OFFSET: vsen_avg_r <= wr_data_r[1:0];
          TSEN_AVG_OFFSET: tsen_avg_r <= wr_data_r[1:0];
          ZC_OFFSET:       zc_r       <= wr_data_r[5:0];
          default:         ;  // Result registers stay as measured
        endcase
      end
    end
  end

  // ***************************************************************
  // Serial port slave
  // ***************************************************************
  typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} link_state_t;
  link_state_t state_r;
  logic        scl_q_r, sda_q_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  ptr_r;
  logic        rw_r;
  logic [7:0]  rd_byte;
  logic        scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise   = scl_s & ~scl_q_r;
  assign scl_fall   = ~scl_s & scl_q_r;
  assign start_seen = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_seen  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign rd_byte    = reg_read(ptr_r);

  // Line history for edge and condition detection. The line is only ever
  // pulled low, so the data level is fixed at zero.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_q_r <= 1'b0;
      sda_q_r <= 1'b0;
      sda_o   <= 1'b0;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      sda_o   <= 1'b0;
    end
  end

  // Byte engine. Bits are sampled on scl rise and driven on scl fall,
  // so data never changes while the clock is high.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      ptr_r     <= 8'h00;
      rw_r      <= 1'b0;
      sda_oe_o  <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_seen) begin
        state_r   <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_o  <= 1'b0;
      end else if (stop_seen) begin
        state_r  <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_PTR, ST_WR: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              shift_r   <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == slave_addr_i) begin
                  rw_r     <= shift_r[0];
                  sda_oe_o <= 1'b1;
                  state_r  <= ST_ADDR_ACK;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else if (state_r == ST_PTR) begin
                ptr_r    <= shift_r;
                sda_oe_o <= 1'b1;
                state_r  <= ST_PTR_ACK;
              end else begin
                wr_stb_r  <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= shift_r;
                sda_oe_o  <= 1'b1;
                state_r   <= ST_WR_ACK;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_r) begin
                sda_oe_o  <= ~rd_byte[7];
                shift_r   <= {rd_byte[6:0], 1'b0};
                bit_cnt_r <= 4'h1;
                state_r   <= ST_RD;
              end else begin
                sda_oe_o <= 1'b0;
                state_r  <= ST_PTR;
              end
            end
          end
          ST_PTR_ACK, ST_WR_ACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              state_r  <= ST_WR;
              if (state_r == ST_WR_ACK) begin
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt_r != 4'h8) begin
                sda_oe_o  <= ~shift_r[7];
                shift_r   <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end else begin
                sda_oe_o <= 1'b0;
                ptr_r    <= ptr_r + 8'h01;
                state_r  <= ST_RD_ACK;
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise && sda_s) begin
              state_r <= ST_IDLE;
            end else if (scl_fall) begin
              sda_oe_o  <= ~rd_byte[7];
              shift_r   <= {rd_byte[6:0], 1'b0};
              bit_cnt_r <= 4'h1;
              state_r   <= ST_RD;
            end
          end
          default: begin
            state_r  <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // Power state and mode outputs
  // ***************************************************************
  logic [1:0] ps_eff;

  // Code 3 from the comparators is treated as high to stay safe.
  assign ps_eff = (strap_s && mode_r.strap_lock_high) ? PS_HIGH :
                  (psi_s[1] ? PS_HIGH : psi_s);

  // All controls are registered so the power stage sees clean levels.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_state_eff_o        <= PS_LOW;
      pulse_skip_en_o          <= 1'b0;
      auto_phase_shedding_en_o <= 1'b0;
      full_phase_o             <= 1'b0;
    end else begin
      power_state_eff_o        <= ps_eff;
      pulse_skip_en_o          <= (ps_eff == PS_LOW) && !mode_r.pulse_skip_off;
      auto_phase_shedding_en_o <= (ps_eff == PS_MID) && !mode_r.shed_off;
      full_phase_o             <= (ps_eff == PS_HIGH) ||
                                  ((ps_eff == PS_MID) && mode_r.shed_off);
    end
  end

  // ***************************************************************
  // Zero-cross threshold
  // ***************************************************************
  // The offset is a signed count of 0.31 mV steps, two's complement.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zero_cross_detect_offset_en_o <= 1'b0;
      zero_cross_detect_offset_o    <= 5'h00;
    end else begin
      zero_cross_detect_offset_en_o <= zc_r.offset_en;
      if (!zc_r.offset_en) begin
        zero_cross_detect_offset_o <= 5'h00;
      end else if (zc_r.negative) begin
        zero_cross_detect_offset_o <= 5'(5'h00 - {1'b0, zc_r.magnitude});
      end else begin
        zero_cross_detect_offset_o <= {1'b0, zc_r.magnitude};
      end
    end
  end

endmodule

`default_nettype wire

// file: verification/pmon_asserts.sv
/*
  Checker for the power-state decode and zero-cross outputs of the bank.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module pmon_asserts
  import pmon_pkg::*;
(
  // Clock and reset.
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  // Pins and controls watched.
  input wire logic [1:0] power_state_input_i,
  input wire logic       strap_pin_three_float_i,
  input wire logic [1:0] power_state_eff_o,
  input wire logic       pulse_skip_en_o,
  input wire logic       auto_phase_shedding_en_o,
  input wire logic       full_phase_o,
  input wire logic       zero_cross_detect_offset_en_o,
  input wire logic [4:0] zero_cross_detect_offset_o
);
  // ***************************************************************
  // Helper logic and assertions
  // ***************************************************************
  logic [2:0] up_r;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // Edges since reset; the pin pipeline is three deep, so $past needs four.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h4) begin
      up_r <= up_r + 3'h1;
    end
  end

  a_eff_follows_pin: assert property ((up_r == 3'h4) && !$past(strap_pin_three_float_i, 3) |->
    power_state_eff_o == (($past(power_state_input_i, 3) == 2'h3) ? PS_HIGH :
    $past(power_state_input_i, 3))) else $error("effective state does not follow pin");
  a_eff_legal: assert property (power_state_eff_o != 2'h3)
    else $error("effective state code 3");
  a_high_full: assert property (power_state_eff_o == PS_HIGH |->
    full_phase_o && !auto_phase_shedding_en_o && !pulse_skip_en_o) else $error("high not full");
  a_skip_low_only: assert property (pulse_skip_en_o |-> power_state_eff_o == PS_LOW)
    else $error("pulse skip outside low state");
  a_low_no_full: assert property (power_state_eff_o == PS_LOW |->
    !full_phase_o && !auto_phase_shedding_en_o) else $error("low state runs phases");
  a_shed_mid_only: assert property (auto_phase_shedding_en_o |-> power_state_eff_o == PS_MID)
    else $error("shedding outside mid state");
  a_mid_one_mode: assert property (power_state_eff_o == PS_MID |->
    (auto_phase_shedding_en_o != full_phase_o) && !pulse_skip_en_o) else $error("mid mode bad");
  a_zc_off_zero: assert property (!zero_cross_detect_offset_en_o |->
    zero_cross_detect_offset_o == 5'h00) else $error("offset applied while disabled");

  c_skip: cover property (pulse_skip_en_o);
  c_shed: cover property (auto_phase_shedding_en_o);
  c_mid_full: cover property (full_phase_o && power_state_eff_o == PS_MID);
endmodule

bind phase_mode_adc_monitor_regs pmon_asserts u_pmon_asserts (.mclk_i, .rst_b_i,
  .power_state_input_i, .strap_pin_three_float_i, .power_state_eff_o, .pulse_skip_en_o,
  .auto_phase_shedding_en_o, .full_phase_o, .zero_cross_detect_offset_en_o,
  .zero_cross_detect_offset_o);

`default_nettype wire

// file: verification/phase_mode_adc_monitor_regs_test.sv
/*
  Self-checking bench for the register bank, driving the serial port pins.
  Assumes an open-drain data line with a pull-up and short sample periods.
*/
`timescale 1ns/1ps
`default_nettype none

module phase_mode_adc_monitor_regs_test
  import pmon_pkg::*;
;
  // ***************************************************************
  // Signals and design
  // ***************************************************************
  localparam logic [6:0] DEV = 7'h24;
  logic       mclk_i, rst_b_i, scl, sda_m, sda_o, sda_oe, strap, skip, shed, full, zen;
  logic [1:0] power_state_input, eff;
  logic [7:0] c_im, c_vs, c_ts;
  logic [4:0] zoff;
  int         failures, checks_done;
  wire        sda_w = sda_m & (~sda_oe | sda_o);

`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

  phase_mode_adc_monitor_regs #(.IMON_CYC(128), .VSEN_CYC(4), .TSEN_CYC(4))
  u_phase_mode_adc_monitor_regs (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .slave_addr_i(DEV),
    .power_state_input_i(power_state_input), .strap_pin_three_float_i(strap),
    .current_monitor_voltage_code_i(c_im), .voltage_sense_code_i(c_vs),
    .temperature_sense_voltage_code_i(c_ts), .power_state_eff_o(eff),
    .pulse_skip_en_o(skip), .auto_phase_shedding_en_o(shed), .full_phase_o(full),
    .zero_cross_detect_offset_en_o(zen), .zero_cross_detect_offset_o(zoff));

  always #12.5 mclk_i = ~mclk_i;

  // ***************************************************************
  // Serial port tasks
  // ***************************************************************
  // Eight clocks a half bit keeps well clear of the synchroniser delay.
  task hp; repeat (8) @(negedge mclk_i); endtask
  task bitx(input logic b, output logic r);
    sda_m = b; hp; scl = 1'b1; hp; r = sda_w; scl = 1'b0; hp;
  endtask
  task sta; sda_m = 1'b1; hp; scl = 1'b1; hp; sda_m = 1'b0; hp; scl = 1'b0; hp; endtask
  task sto; sda_m = 1'b0; hp; scl = 1'b1; hp; sda_m = 1'b1; hp; endtask
  task xb(input logic [7:0] b, input logic ab, output logic [7:0] d, output logic a);
    for (int i = 7; i >= 0; i--) bitx(b[i], d[i]);
    bitx(ab, a);
  endtask
  task wr(input logic [7:0] p, v);
    logic [7:0] d;
    logic       a;
    sta; xb({DEV, 1'b0}, 1'b1, d, a); xb(p, 1'b1, d, a); xb(v, 1'b1, d, a);
    `CHK(a, 1'b0)
    sto;
  endtask
  task rd(input logic [7:0] p, output logic [7:0] v);
    logic [7:0] d;
    logic       a;
    sta; xb({DEV, 1'b0}, 1'b1, d, a); xb(p, 1'b1, d, a);
    sta; xb({DEV, 1'b1}, 1'b1, d, a); xb(8'hff, 1'b1, v, a); sto;
  endtask
  task rc(input logic [7:0] p, e);
    logic [7:0] v;
    rd(p, v);
    `CHK(v, e)
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task t_reset;
    `CHK({skip, zen, zoff}, {1'b0, 1'b1, 5'h1e})
    rc(MODE_OFFSET, {5'h00, MODE_RESET});
    for (int o = 0; o < 3; o++) rc(IMON_RES_OFFSET + 8'(o), RES_RESET);
    for (int o = 0; o < 3; o++) rc(IMON_AVG_OFFSET + 8'(o), 8'h00);
    rc(ZC_OFFSET, {2'h0, ZC_RESET});
    rc(8'h50, 8'h00);
    $display("reset test done");
  endtask
  // Expected value is {eff, skip, shed, full}.
  task pm(input logic [1:0] p, input logic [2:0] m, input logic f, input logic [4:0] e);
    power_state_input = p; strap = f; wr(MODE_OFFSET, {5'h00, m}); hp;
    `CHK({eff, skip, shed, full}, e)
  endtask
  task t_mode;
    pm(PS_LOW, 3'h0, 1'b0, {PS_LOW, 3'b100});
    pm(PS_LOW, 3'h2, 1'b0, {PS_LOW, 3'b000});
    pm(PS_MID, 3'h0, 1'b0, {PS_MID, 3'b010});
    pm(PS_MID, 3'h1, 1'b0, {PS_MID, 3'b001});
    pm(PS_HIGH, 3'h0, 1'b0, {PS_HIGH, 3'b001});
    pm(2'h3, 3'h0, 1'b0, {PS_HIGH, 3'b001});
    pm(PS_LOW, 3'h4, 1'b1, {PS_HIGH, 3'b001});
    pm(PS_LOW, 3'h4, 1'b0, {PS_LOW, 3'b100});
    pm(PS_LOW, 3'h0, 1'b1, {PS_LOW, 3'b100});
    $display("mode test done");
  endtask
  task zc(input logic [5:0] v, input logic [5:0] e);
    wr(ZC_OFFSET, {2'h0, v}); hp;
    `CHK({zen, zoff}, e)
  endtask
  task t_zc;
    zc(6'h05, 6'h00);
    zc(6'h2f, 6'h2f);
    zc(6'h3f, 6'h31);
    zc(6'h20, 6'h20);
    $display("zero-cross test done");
  endtask
  task t_lock;
    wr(LOCK_OFFSET, LOCK_KEY); rc(LOCK_OFFSET, LOCK_KEY);
    wr(MODE_OFFSET, 8'h07); wr(IMON_AVG_OFFSET, 8'h03); wr(ZC_OFFSET, 8'h00);
    rc(MODE_OFFSET, 8'h00); rc(IMON_AVG_OFFSET, 8'h00); rc(ZC_OFFSET, 8'h20);
    `CHK(zen, 1'b1)
    wr(LOCK_OFFSET, 8'ha5); wr(MODE_OFFSET, 8'h07); rc(MODE_OFFSET, 8'h07);
    $display("lock test done");
  endtask
  task t_adc;
    logic [7:0] v;
    c_vs = 8'h5a; c_ts = 8'hc3;
    for (int s = 0; s < 4; s++) begin
      wr(VSEN_AVG_OFFSET, 8'(s)); wr(TSEN_AVG_OFFSET, 8'(s));
      rc(VSEN_AVG_OFFSET, 8'(s)); rc(TSEN_AVG_OFFSET, 8'(s));
      rc(VSEN_RES_OFFSET, 8'h5a); rc(TSEN_RES_OFFSET, 8'hc3);
    end
    wr(IMON_AVG_OFFSET, {6'h00, AVG_SEL_2}); c_im = 8'h21; repeat (3000) @(negedge mclk_i);
    rc(IMON_RES_OFFSET, 8'h21); wr(IMON_RES_OFFSET, 8'h77); rc(IMON_RES_OFFSET, 8'h21);
    c_im = 8'h61; repeat (800) @(negedge mclk_i); rc(IMON_RES_OFFSET, 8'h61);
    // A 16-sample window cannot turn over inside one short read.
    wr(IMON_AVG_OFFSET, {6'h00, AVG_SEL_16}); repeat (4200) @(negedge mclk_i); c_im = 8'h21;
    rd(IMON_RES_OFFSET, v);
    `CHK(v, 8'h61)
    repeat (4500) @(negedge mclk_i); rc(IMON_RES_OFFSET, 8'h21);
    $display("adc test done");
  endtask

  task summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Main sequence; scl and sda idle high, other pins and codes zero from time zero.
  initial begin
    mclk_i = 1'b0; rst_b_i = 1'b0; scl = 1'b1; sda_m = 1'b1; power_state_input = PS_LOW; strap = 1'b0;
    c_im = 8'h00; c_vs = 8'h00; c_ts = 8'h00; failures = 0; checks_done = 0;
    repeat (10) @(negedge mclk_i);
    rst_b_i = 1'b1; hp;
    t_reset; t_mode; t_zc; t_lock; t_adc;
    summarize;
  end

  // Watchdog against a hung run.
  initial begin
    repeat (90000) @(posedge mclk_i);
    failures++;
    summarize;
  end
endmodule

`default_nettype wire
